/* adc_host_model.sv */
// Host logic model: drives the mode pins and qualifies captured bus data
`default_nettype none
module adc_host_model #(
  // Shutdown wait also covers external reference drivers; raise it for slow ones
  parameter int WAKE_SHUTDOWN = dual_adc_ctrl_pkg::WAKE_SHUTDOWN_CYC,
  parameter int WAKE_STANDBY = dual_adc_ctrl_pkg::WAKE_STANDBY_CYC,
  parameter int WAKE_IDLE = dual_adc_ctrl_pkg::WAKE_IDLE_CYC
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [1:0] mode_i,
  input wire logic bus_oe_n_i,
  output logic power_select_first_o,
  output logic power_select_second_o,
  output logic valid_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] left_q;
  logic [11:0] wait_q;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      {power_select_first_o, power_select_second_o} <= 2'b00;
      left_q <= 2'b00;
      wait_q <= 12'hFFF;
    end else begin
      {power_select_first_o, power_select_second_o} <= mode_i;
      if (mode_i != 2'b11) left_q <= mode_i;
      // Wait sized by the state being left: reference charge, converter start or driver start
      if (bus_oe_n_i) begin
        case (left_q)
          2'b00: wait_q <= 12'(WAKE_SHUTDOWN);
          2'b01: wait_q <= 12'(WAKE_STANDBY);
          default: wait_q <= 12'(WAKE_IDLE);
        endcase
      end else if (wait_q != 12'h000) begin
        wait_q <= wait_q - 12'h001;
      end
    end
  end
  assign valid_o = !bus_oe_n_i && (wait_q == 12'h000);
endmodule // adc_host_model
`default_nettype wire

/* dual_adc_ctrl_pkg.sv */
// Constants and types shared by the dual converter control block
`default_nettype none
package dual_adc_ctrl_pkg;
  localparam int CODE_W = 8;
  // Offset binary anchors: top, bipolar zero, bottom
  localparam logic [7:0] CODE_TOP = 8'hFF;
  localparam logic [7:0] CODE_MID = 8'h80;
  localparam logic [7:0] CODE_BOTTOM = 8'h00;
  // Sample clock is clk_i divided by two; latencies are in clk_i edges (half sample periods)
  localparam int LAT_FIRST_HALVES = 10;
  localparam int LAT_SECOND_HALVES = 11;
  // Mode pin synchroniser depth
  localparam int SYNC_STAGES = 2;
  // Mode age counter used by the checks
  localparam int AGE_W = 4;
  localparam logic [3:0] AGE_MAX = 4'hF;
  localparam logic [3:0] AGE_SETTLED = 4'hC;
  // Wake-up waits kept by the controller outside
  localparam int CLK_PERIOD_PS = 5000;
  localparam int WAKE_SHUTDOWN_NS = 20000;
  localparam int WAKE_STANDBY_PS = 5500000;
  localparam int WAKE_IDLE_NS = 5;
  localparam int WAKE_SHUTDOWN_CYC = (WAKE_SHUTDOWN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WAKE_STANDBY_CYC = (WAKE_STANDBY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WAKE_IDLE_CYC = (WAKE_IDLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Mode code is {first select, second select}
  typedef enum logic [1:0] {
    MODE_SHUTDOWN = 2'b00,
    MODE_STANDBY = 2'b01,
    MODE_IDLE = 2'b10,
    MODE_NORMAL = 2'b11
  } power_mode_t;
endpackage
`default_nettype wire

/* dual_adc_power_mode_output_ctrl.sv */
// Power mode decode, output multiplexing and offset binary coding of a dual 8-bit converter
`default_nettype none
//
// Contract
// - Output code is 8-bit offset binary.
// - Code equals 128 plus signed input steps.
// - Two static mode pins select four states.
// - Both low: shutdown, all off, outputs released.
// - Second high only: standby, converters off.
// - First high only: idle, outputs released.
// - Both high: normal, outputs driven.
// - Re-enabled outputs show last converted word.
// - Both sampled together; first rises, second falls.
// - Indicator high for first, low second.
// - Latency five and five and half cycles.
module dual_adc_power_mode_output_ctrl #(
  parameter int CODE_W = dual_adc_ctrl_pkg::CODE_W
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic power_select_first_i,
  input wire logic power_select_second_i,
  input wire logic [CODE_W-1:0] sample_first_i,
  input wire logic [CODE_W-1:0] sample_second_i,
  output logic [CODE_W-1:0] output_code_bus_o,
  output logic output_code_bus_oe_n_o,
  output logic channel_first_o,
  output logic channel_first_oe_n_o,
  output logic adc_power_o,
  output logic reference_power_o,
  output logic clock_dist_power_o
);

  localparam int LAT_F = dual_adc_ctrl_pkg::LAT_FIRST_HALVES;
  localparam int LAT_S = dual_adc_ctrl_pkg::LAT_SECOND_HALVES;

  // Mode pins come from outside: two flip-flops before use
  logic [1:0] sel_meta_q;
  logic [1:0] sel_sync_q;
  dual_adc_ctrl_pkg::power_mode_t mode;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sel_meta_q <= 2'h0;
      sel_sync_q <= 2'h0;
    end else begin
      sel_meta_q <= {power_select_first_i, power_select_second_i};
      sel_sync_q <= sel_meta_q;
    end
  end

  assign mode = dual_adc_ctrl_pkg::power_mode_t'(sel_sync_q);

  // Offset binary is the signed code with its sign bit inverted
  logic [CODE_W-1:0] enc_first;
  logic [CODE_W-1:0] enc_second;
  assign enc_first = {~sample_first_i[CODE_W-1], sample_first_i[CODE_W-2:0]};
  assign enc_second = {~sample_second_i[CODE_W-1], sample_second_i[CODE_W-2:0]};

  // Conversion pipelines, one stage per clk_i edge
  logic [CODE_W-1:0] first_pipe_q [0:LAT_F-1];
  logic [CODE_W-1:0] second_pipe_q [0:LAT_S-1];

  for (genvar i = 0; i < LAT_S; i++) begin : g_pipe
    always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        second_pipe_q[i] <= dual_adc_ctrl_pkg::CODE_MID;
      end else begin
        second_pipe_q[i] <= (i == 0) ? enc_second : second_pipe_q[(i == 0) ? 0 : i - 1];
      end
    end
    if (i < LAT_F) begin : g_first
      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          first_pipe_q[i] <= dual_adc_ctrl_pkg::CODE_MID;
        end else begin
          first_pipe_q[i] <= (i == 0) ? enc_first : first_pipe_q[(i == 0) ? 0 : i - 1];
        end
      end
    end
  end

  // Output state
  logic phase_q;
  logic phase_d;
  logic [CODE_W-1:0] bus_q;
  logic [CODE_W-1:0] bus_d;
  logic chan_q;
  logic chan_d;
  logic oe_n_q;
  logic oe_n_d;
  logic adc_q;
  logic adc_d;
  logic ref_q;
  logic ref_d;
  logic clkd_q;
  logic clkd_d;
  logic [dual_adc_ctrl_pkg::AGE_W-1:0] age_q;
  logic [dual_adc_ctrl_pkg::AGE_W-1:0] age_d;
  dual_adc_ctrl_pkg::power_mode_t mode_q;

  always_comb begin
    // phase_q low means this edge is the rising sample clock edge
    phase_d = ~phase_q;
    bus_d = bus_q;
    chan_d = chan_q;
    adc_d = 1'b0;
    ref_d = 1'b0;
    clkd_d = 1'b0;
    oe_n_d = 1'b1;
    case (mode)
      dual_adc_ctrl_pkg::MODE_SHUTDOWN: begin
        oe_n_d = 1'b1;
      end
      dual_adc_ctrl_pkg::MODE_STANDBY: begin
        ref_d = 1'b1;
        clkd_d = 1'b1;
      end
      dual_adc_ctrl_pkg::MODE_IDLE: begin
        adc_d = 1'b1;
        ref_d = 1'b1;
        clkd_d = 1'b1;
      end
      dual_adc_ctrl_pkg::MODE_NORMAL: begin
        adc_d = 1'b1;
        ref_d = 1'b1;
        clkd_d = 1'b1;
        oe_n_d = 1'b0;
      end
      default: begin
        oe_n_d = 1'b1;
      end
    endcase
    // Words advance only once converters ran last cycle too, so a wake first re-shows the held word
    if (adc_d && adc_q) begin
      if (!phase_q) begin
        bus_d = first_pipe_q[LAT_F-1];
      end else begin
        bus_d = second_pipe_q[LAT_S-1];
      end
      chan_d = ~phase_q;
    end
    age_d = (mode != mode_q) ? '0 : ((age_q == dual_adc_ctrl_pkg::AGE_MAX) ? age_q : age_q + 4'h1);
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase_q <= 1'b0;
      bus_q <= dual_adc_ctrl_pkg::CODE_MID;
      chan_q <= 1'b0;
      oe_n_q <= 1'b1;
      adc_q <= 1'b0;
      ref_q <= 1'b0;
      clkd_q <= 1'b0;
      age_q <= '0;
      mode_q <= dual_adc_ctrl_pkg::MODE_SHUTDOWN;
    end else begin
      phase_q <= phase_d;
      bus_q <= bus_d;
      chan_q <= chan_d;
      oe_n_q <= oe_n_d;
      adc_q <= adc_d;
      ref_q <= ref_d;
      clkd_q <= clkd_d;
      age_q <= age_d;
      mode_q <= mode;
    end
  end

  assign output_code_bus_o = bus_q;
  assign output_code_bus_oe_n_o = oe_n_q;
  assign channel_first_o = chan_q;
  assign channel_first_oe_n_o = oe_n_q;
  assign adc_power_o = adc_q;
  assign reference_power_o = ref_q;
  assign clock_dist_power_o = clkd_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  logic settled_on;
  assign settled_on = (mode == mode_q) && adc_d && (age_q >= dual_adc_ctrl_pkg::AGE_SETTLED);

  sequence s_first_edge;
    settled_on && !phase_q;
  endsequence
  sequence s_second_edge;
    settled_on && phase_q;
  endsequence

  a_first_code_latency: assert property (s_first_edge |=> bus_q == $past(enc_first, 11))
    else $error("first channel word wrong or late");
  a_second_code_latency: assert property (s_second_edge |=> bus_q == $past(enc_second, 12))
    else $error("second channel word wrong or late");
  a_mid_code_zero: assert property (s_first_edge ##0 ($past(sample_first_i, 10) == 8'h00)
      |=> bus_q == dual_adc_ctrl_pkg::CODE_MID)
    else $error("bipolar zero not coded as midscale");
  a_code_offset_sum: assert property (s_second_edge
      |=> bus_q == 8'(8'h80 + $past(sample_second_i, 12)))
    else $error("code is not 128 plus signed input");
  a_indicator_alternates: assert property (s_first_edge ##1 settled_on |-> chan_q ##1 !chan_q)
    else $error("channel indicator not following sample clock");
  a_shutdown_all_off: assert property (mode == dual_adc_ctrl_pkg::MODE_SHUTDOWN
      |=> !adc_q && !ref_q && !clkd_q && oe_n_q)
    else $error("shutdown state powers or drives");
  a_standby_sections: assert property (mode == dual_adc_ctrl_pkg::MODE_STANDBY
      |=> !adc_q && ref_q && clkd_q && oe_n_q)
    else $error("standby sections wrong");
  a_idle_sections: assert property (mode == dual_adc_ctrl_pkg::MODE_IDLE
      |=> adc_q && ref_q && clkd_q && oe_n_q)
    else $error("idle sections wrong");
  a_normal_drives: assert property (mode == dual_adc_ctrl_pkg::MODE_NORMAL
      |=> adc_q && ref_q && clkd_q && !oe_n_q)
    else $error("normal mode not driving");
  a_hold_last_word: assert property (!adc_d [*2] |=> $stable(bus_q) && $stable(chan_q))
    else $error("held word changed while converters off");
  a_turn_on_word: assert property (adc_d && !adc_q |=> $stable(bus_q) && $stable(chan_q))
    else $error("wake did not present the last converted word");
  a_pin_to_state: assert property (({power_select_first_i, power_select_second_i} == 2'b11) [*3]
      |=> !oe_n_q)
    else $error("mode pins not reaching output enable in three cycles");

endmodule // dual_adc_power_mode_output_ctrl
`default_nettype wire

/* test_dual_adc_power_mode_output_ctrl.sv */
// Testbench of the dual converter power mode and output control block
`default_nettype none
module test_dual_adc_power_mode_output_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] PW_TAB [4] = '{8'h11, 8'h17, 8'h1F, 8'h0E};
  // Zero, both full scales and one step, mixed into the random stream
  localparam logic [7:0] EDGE_TAB [4] = '{8'h00, 8'h7F, 8'h80, 8'h01};
  logic [7:0] pick_a, pick_b;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [1:0] mode_q = 2'b00;
  logic [7:0] samp_a = 8'h00;
  logic [7:0] samp_b = 8'h00;
  logic [7:0] bus, held;
  logic oe_n, chan, chan_oe_n, adc_pw, ref_pw, clk_pw, sel_a, sel_b, valid;
  logic chan_prev = 1'b0;
  logic valid_prev = 1'b0;
  logic frozen = 1'b0;
  logic [15:0] hist [$];
  logic [31:0] seed = 32'h95F8BAC7;
  int failures = 0;
  int n_checks = 0;
  initial forever #2.5 clk_i = ~clk_i;
  adc_host_model host_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .mode_i(mode_q),
    .bus_oe_n_i(oe_n), .power_select_first_o(sel_a), .power_select_second_o(sel_b), .valid_o(valid));
  dual_adc_power_mode_output_ctrl dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .power_select_first_i(sel_a),
    .power_select_second_i(sel_b), .sample_first_i(samp_a), .sample_second_i(samp_b), .output_code_bus_o(bus),
    .output_code_bus_oe_n_o(oe_n), .channel_first_o(chan), .channel_first_oe_n_o(chan_oe_n),
    .adc_power_o(adc_pw), .reference_power_o(ref_pw), .clock_dist_power_o(clk_pw));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Random two's complement stream; the note holds both expected offset binary words
  always @(posedge clk_i) begin
    seed = xs(seed);
    pick_a = (seed[31:29] == 3'h0) ? EDGE_TAB[seed[28:27]] : seed[7:0];
    pick_b = (seed[26:24] == 3'h0) ? EDGE_TAB[seed[23:22]] : seed[15:8];
    samp_a <= pick_a;
    samp_b <= pick_b;
    hist.push_back({pick_a ^ 8'h80, pick_b ^ 8'h80});
  end
  // Entry 1 was sampled ten edges back, entry 0 eleven
  always @(negedge clk_i) begin
    while (hist.size() > 13) void'(hist.pop_front());
    if (valid && valid_prev) check({7'h00, chan}, {7'h00, ~chan_prev});
    if (valid) check(bus, chan ? hist[1][15:8] : hist[0][7:0]);
    if (frozen && !oe_n) begin
      check(bus, held);
      frozen = 1'b0;
    end
    if (oe_n) held = bus;
    chan_prev = chan;
    valid_prev = valid;
  end
  initial begin
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(negedge clk_i);
    check(bus, 8'h80);
    check({2'h0, chan_oe_n, oe_n, chan, adc_pw, ref_pw, clk_pw}, 8'h30);
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_i);
      mode_q <= 2'(m);
      repeat (8) @(posedge clk_i);
      @(negedge clk_i);
      check({3'h0, chan_oe_n, adc_pw, ref_pw, clk_pw, oe_n}, PW_TAB[m]);
      frozen = (m < 2);
      @(posedge clk_i);
      mode_q <= 2'b11;
      for (int k = 0; k < 5000 && !valid; k++) @(negedge clk_i);
      if (!valid) begin
        failures++;
        break;
      end
      repeat (60) @(negedge clk_i);
      $display("Wake from mode %0d and stream done", m);
    end
    finish_test();
  end
endmodule // test_dual_adc_power_mode_output_ctrl
`default_nettype wire
